// ---- hdl/rcc_map.vh ----
// Constants for the refresh configuration host controller.
// Assumes inclusion by rcc_host.v only; definitions only.
`ifndef RCC_MAP_VH
`define RCC_MAP_VH
// Software register offsets of the controller
`define RCC_OFS_CFG 4'h0
`define RCC_OFS_CTRL 4'h1
`define RCC_OFS_STAT 4'h2
`define RCC_OFS_SHADOW 4'h3
// Field positions of the refresh configuration word
`define RCC_SEL_BIT 19
`define RCC_PAGE_BIT 7
`define RCC_TEMP_HI 6
`define RCC_TEMP_LO 5
`define RCC_DEEP_BIT 4
`define RCC_REGION_HI 2
`define RCC_REGION_LO 0
// Device defaults: page off, 85 C range, deep sleep forbidden, full array
`define RCC_CFG_RESET 20'h00070
// Mask of writable positions; reserved 18:8 and 3 forced to zero
`define RCC_CFG_MASK 20'h000f7
// Times in ns and cycles at 25 MHz (40 ns)
`define RCC_CLK_NS 40
`define RCC_WR_NS 70
`define RCC_WR_CYC ((`RCC_WR_NS + `RCC_CLK_NS - 1) / `RCC_CLK_NS)
`define RCC_SLEEP_NS 10000
`define RCC_SLEEP_CYC (`RCC_SLEEP_NS / `RCC_CLK_NS + 1)
`define RCC_CSL_NS 10000
`define RCC_CSL_CYC (`RCC_CSL_NS / `RCC_CLK_NS)
`define RCC_WAKE_NS 150000
`define RCC_WAKE_CYC ((`RCC_WAKE_NS + `RCC_CLK_NS - 1) / `RCC_CLK_NS)
`endif

// ---- hdl/rcc_host.v ----
// Host controller that programs the refresh configuration register of a
// pseudo-static memory and steers its sleep pin into low-power states.
// Starts a command only once i_mem_busy is low, and assumes that
// software owns the plain register port on i_ref_clk.
`timescale 1ns/1ps
`include "rcc_map.vh"

module rcc_host #(
    parameter SLEEP_CYC = `RCC_SLEEP_CYC,
    parameter WAKE_CYC = `RCC_WAKE_CYC,
    parameter CSL_CYC = `RCC_CSL_CYC
) (
    input wire i_ref_clk, // 25 MHz clock
    input wire i_nrst, // Asynchronous reset, active low
    input wire [3:0] i_addr, // Software register address
    input wire [31:0] i_wdata, // Software write data
    input wire i_wr, // Software write strobe
    input wire i_rd, // Software read strobe
    input wire i_mem_busy, // Other memory traffic in progress
    output reg [31:0] o_rdata, // Read data, one cycle after read
    output reg [19:0] o_mem_addr, // Memory address lines
    output reg o_chip_select_n, // Memory chip select, active low
    output reg o_write_en_n, // Memory write enable, active low
    output reg o_sleep_pin_n, // Memory sleep pin, active low
    output wire o_busy, // Command in progress
    output reg o_access_ok // Memory may take normal accesses
);

    localparam ST_IDLE = 3'h0;
    localparam ST_SETUP = 3'h1;
    localparam ST_PULSE = 3'h2;
    localparam ST_HOLD = 3'h3;
    localparam ST_LOW = 3'h4;
    localparam ST_WAKE = 3'h5;

    reg rst_meta_q;
    reg rst_n_q;
    reg [19:0] cfg_q; // Value software wants written
    reg [19:0] shadow_q; // Value last loaded into the device
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [17:0] cnt_q;
    reg [17:0] cnt_d;
    reg sleep_req_q; // Software asks for sleep pin low
    reg wr_cmd_q; // Pending register write
    reg deep_q; // Present low state is deep sleep
    reg lowstate_q; // Device is in partial or deep state
    reg err_q; // Partial entry requested with deep sleep enabled, sticky
    reg [19:0] mem_addr_d;
    reg cs_n_d;
    reg we_n_d;
    reg sleep_n_d;
    wire [19:0] wr_word;
    wire ctrl_wr;

    // Reset release through two flip-flops
    always @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // Reserved positions and selector are cleared before driving the bus
    assign wr_word = cfg_q & `RCC_CFG_MASK;
    assign ctrl_wr = i_wr && (i_addr == `RCC_OFS_CTRL);
    assign o_busy = (state_q != ST_IDLE) || wr_cmd_q;

    // Software registers; requests stand until the sequencer takes them
    always @(posedge i_ref_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            cfg_q <= `RCC_CFG_RESET;
            wr_cmd_q <= 1'b0;
            sleep_req_q <= 1'b0;
            err_q <= 1'b0;
            o_rdata <= 32'h00000000;
        end
        else
        begin
            if (i_wr && (i_addr == `RCC_OFS_CFG) && state_q == ST_IDLE)
            begin
                cfg_q <= i_wdata[19:0] & `RCC_CFG_MASK;
            end
            if (ctrl_wr && i_wdata[0] && !sleep_req_q)
            begin
                wr_cmd_q <= 1'b1;
            end
            else if (state_q == ST_SETUP)
            begin
                wr_cmd_q <= 1'b0;
            end
            if (ctrl_wr)
            begin
                sleep_req_q <= i_wdata[1];
            end
            // Partial entry with deep sleep still enabled is flagged
            if (ctrl_wr && i_wdata[1] && !shadow_q[`RCC_DEEP_BIT] && i_wdata[3])
            begin
                err_q <= 1'b1;
            end
            else if (ctrl_wr && i_wdata[2])
            begin
                err_q <= 1'b0;
            end
            o_rdata <= 32'h00000000;
            if (i_rd)
            begin
                case (i_addr)
                    `RCC_OFS_CFG: o_rdata <= {12'h000, cfg_q};
                    `RCC_OFS_CTRL: o_rdata <= {30'h00000000, sleep_req_q, wr_cmd_q};
                    `RCC_OFS_STAT: o_rdata <= {26'h0000000, err_q, deep_q, lowstate_q,
                        o_access_ok, o_busy, ~o_sleep_pin_n};
                    `RCC_OFS_SHADOW: o_rdata <= {12'h000, shadow_q};
                    default: o_rdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Sequencer: set-register write, sleep low timing, wake guard
    always @*
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        mem_addr_d = o_mem_addr;
        cs_n_d = 1'b1;
        we_n_d = 1'b1;
        sleep_n_d = 1'b1;
        case (state_q)
            ST_IDLE:
            begin
                cnt_d = 18'h00000;
                if (wr_cmd_q && !i_mem_busy)
                begin
                    state_d = ST_SETUP;
                    mem_addr_d = wr_word;
                    sleep_n_d = 1'b0;
                end
                else if (sleep_req_q && !i_mem_busy)
                begin
                    state_d = ST_LOW;
                    sleep_n_d = 1'b0;
                end
            end
            ST_SETUP:
            begin
                // Sleep pin low ahead of write enable for setup
                sleep_n_d = 1'b0;
                cs_n_d = 1'b0;
                we_n_d = 1'b0;
                cnt_d = 18'h00000;
                state_d = ST_PULSE;
            end
            ST_PULSE:
            begin
                sleep_n_d = 1'b0;
                cs_n_d = 1'b0;
                we_n_d = 1'b0;
                cnt_d = cnt_q + 18'h00001;
                // The write count ends the select-low stretch long before the limit
                if (cnt_q >= `RCC_WR_CYC - 1 || cnt_q >= CSL_CYC - 1)
                begin
                    we_n_d = 1'b1;
                    state_d = ST_HOLD;
                end
            end
            ST_HOLD:
            begin
                // Sleep pin held past write enable rise; chip select toggles off
                sleep_n_d = 1'b0;
                cs_n_d = 1'b1;
                state_d = ST_IDLE;
            end
            ST_LOW:
            begin
                sleep_n_d = 1'b0;
                if (cnt_q < SLEEP_CYC)
                begin
                    cnt_d = cnt_q + 18'h00001;
                end
                if (!sleep_req_q)
                begin
                    sleep_n_d = 1'b1;
                    cnt_d = 18'h00000;
                    state_d = deep_q ? ST_WAKE : ST_IDLE;
                end
            end
            ST_WAKE:
            begin
                // Only deselect is issued while the device wakes
                cs_n_d = 1'b1;
                cnt_d = cnt_q + 18'h00001;
                if (cnt_q >= WAKE_CYC - 1)
                begin
                    state_d = ST_IDLE;
                end
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Pin and state registers
    always @(posedge i_ref_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            state_q <= ST_IDLE;
            cnt_q <= 18'h00000;
            o_mem_addr <= 20'h00000;
            o_chip_select_n <= 1'b1;
            o_write_en_n <= 1'b1;
            o_sleep_pin_n <= 1'b1;
            shadow_q <= `RCC_CFG_RESET;
            lowstate_q <= 1'b0;
            deep_q <= 1'b0;
            o_access_ok <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            o_mem_addr <= mem_addr_d;
            o_chip_select_n <= cs_n_d;
            o_write_en_n <= we_n_d;
            o_sleep_pin_n <= sleep_n_d;
            // Device keeps the value until rewritten
            if (state_q == ST_HOLD)
            begin
                shadow_q <= o_mem_addr;
            end
            // Low state begins once the sleep pin was low long enough
            if (state_q == ST_LOW && cnt_q >= SLEEP_CYC - 1 && sleep_req_q)
            begin
                lowstate_q <= 1'b1;
                deep_q <= !shadow_q[`RCC_DEEP_BIT];
            end
            else if (state_q != ST_LOW)
            begin
                lowstate_q <= 1'b0;
            end
            if (state_q == ST_IDLE)
            begin
                deep_q <= 1'b0;
            end
            o_access_ok <= (state_d == ST_IDLE) && !lowstate_q;
        end
    end

endmodule // rcc_host

// ---- verification/rcc_mem_model.sv ----
// Memory-side model: refresh configuration word and low-power states.
// Assumes host pins change on the same reference clock used as time base.
`timescale 1ns/1ps
module rcc_mem_model #(
    parameter LOW_CYC = 8
) (
    input wire i_ref_clk, // Free time reference
    input wire [19:0] i_addr, // Address lines
    input wire i_cs_n, // Chip select, active low
    input wire i_we_n, // Write enable, active low
    input wire i_sleep_n, // Sleep pin, active low
    output reg [19:0] o_cfg, // Stored configuration word
    output wire o_partial, // Partial refresh state
    output wire o_deep // Deep sleep state
);
    reg [15:0] low_q;
    initial o_cfg = 20'h00070;
    initial low_q = 16'h0;
    // Load on the closing write edge; kept through sleep until reloaded
    always @(posedge i_we_n)
    begin
        if (!i_cs_n && !i_sleep_n && !i_addr[19])
            o_cfg <= i_addr;
    end
    // Selected cycles restart the count so a register write never sleeps
    always @(posedge i_ref_clk)
        low_q <= (i_sleep_n || !i_cs_n) ? 16'h0 : low_q + 16'h1;
    assign o_partial = (low_q > LOW_CYC) && o_cfg[4];
    assign o_deep = (low_q > LOW_CYC) && !o_cfg[4];
endmodule // rcc_mem_model

// ---- verification/rcc_host_asserts.sv ----
// Checker on the host controller ports; bound into every rcc_host.
// Assumes one clock and the raw asynchronous reset.
`timescale 1ns/1ps
module rcc_host_asserts #(
    parameter SLEEP_CYC = 251,
    parameter WAKE_CYC = 3750,
    parameter CSL_CYC = 250
) (
    input wire i_ref_clk, // Clock
    input wire i_nrst, // Reset, active low
    input wire i_mem_busy, // Other traffic
    input wire [19:0] o_mem_addr, // Address lines
    input wire o_chip_select_n, // Chip select
    input wire o_write_en_n, // Write enable
    input wire o_sleep_pin_n, // Sleep pin
    input wire o_access_ok // Accesses allowed
);
    reg [15:0] csl_q;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    // Length of the current select-low stretch
    always @(posedge i_ref_clk or negedge i_nrst)
        if (!i_nrst) csl_q <= 16'h0;
        else csl_q <= o_chip_select_n ? 16'h0 : csl_q + 16'h1;
    sel_zero_a: assert property (!o_write_en_n |-> o_mem_addr[19:8] == 12'h0
        && !o_mem_addr[3]) else $error("reserved or selector line high");
    write_frame_a: assert property (!o_write_en_n |-> !o_chip_select_n
        && !o_sleep_pin_n) else $error("write without select and sleep low");
    we_width_a: assert property ($fell(o_write_en_n) |-> !o_write_en_n[*2]
        ##1 o_write_en_n) else $error("write pulse width wrong");
    sleep_hold_a: assert property ($rose(o_write_en_n) |-> !o_sleep_pin_n
        ##1 (!o_sleep_pin_n && o_chip_select_n) ##1 o_sleep_pin_n)
        else $error("sleep hold after write wrong");
    idle_gate_a: assert property ($fell(o_sleep_pin_n) |->
        !$past(i_mem_busy)) else $error("started while traffic busy");
    // Own register writes also drop access_ok, but always with the sleep pin low
    wake_deselect_a: assert property (!o_access_ok && o_sleep_pin_n |->
        o_chip_select_n && o_write_en_n) else $error("select during wake guard");
    cs_limit_a: assert property (csl_q < CSL_CYC)
        else $error("select held low too long");
    addr_stable_a: assert property (!o_write_en_n && $past(!o_write_en_n) |->
        $stable(o_mem_addr)) else $error("address moved during write");
endmodule // rcc_host_asserts
bind rcc_host rcc_host_asserts #(.SLEEP_CYC(SLEEP_CYC), .WAKE_CYC(WAKE_CYC), .CSL_CYC(CSL_CYC))
    u_chk (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_mem_busy(i_mem_busy),
    .o_mem_addr(o_mem_addr), .o_chip_select_n(o_chip_select_n), .o_write_en_n(o_write_en_n),
    .o_sleep_pin_n(o_sleep_pin_n), .o_access_ok(o_access_ok));

// ---- verification/tb_rcc_host.sv ----
// Self-checking bench for rcc_host with a memory-side model.
// Assumes short SLEEP_CYC and WAKE_CYC values set below.
`timescale 1ns/1ps
module tb_rcc_host;
    localparam [31:0] ALL = 32'hffffffff;
    reg i_ref_clk = 1'b0, i_nrst = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_mem_busy = 1'b0;
    reg [3:0] i_addr = 4'h0;
    reg [31:0] i_wdata = 32'h0, seed = 32'h32, d;
    reg [31:0] exp_q[$], msk_q[$];
    reg [11:0] regions = 12'hb18;
    reg rd_seen = 1'b0;
    wire [31:0] o_rdata;
    wire [19:0] o_mem_addr, m_cfg;
    wire cs_n, we_n, sl_n, o_busy, o_access_ok, m_part, m_deep;
    integer failures = 0, checked = 0, cyc = 0, i;
    initial forever #20 i_ref_clk = ~i_ref_clk;
    rcc_host #(.SLEEP_CYC(8), .WAKE_CYC(10)) dut (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_mem_busy(i_mem_busy),
        .o_rdata(o_rdata), .o_mem_addr(o_mem_addr), .o_chip_select_n(cs_n),
        .o_write_en_n(we_n), .o_sleep_pin_n(sl_n), .o_busy(o_busy), .o_access_ok(o_access_ok));
    rcc_mem_model #(.LOW_CYC(8)) mem (.i_ref_clk(i_ref_clk), .i_addr(o_mem_addr),
        .i_cs_n(cs_n), .i_we_n(we_n), .i_sleep_n(sl_n), .o_cfg(m_cfg), .o_partial(m_part),
        .o_deep(m_deep));
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    task summarize;
    begin
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask
    task cmp(input [31:0] got, input [31:0] exp, input [31:0] msk);
    begin
        checked = checked + 1;
        if ((got & msk) !== (exp & msk))
        begin
            failures = failures + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task wr(input [3:0] a, input [31:0] v);
    begin
        @(posedge i_ref_clk);
        i_addr <= a; i_wdata <= v; i_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    end
    endtask
    // Read notes its expectation; the watcher compares it one cycle later
    task rd(input [3:0] a, input [31:0] e, input [31:0] m);
    begin
        @(posedge i_ref_clk);
        i_addr <= a; i_rd <= 1'b1; exp_q.push_back(e); msk_q.push_back(m);
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
    end
    endtask
    task wait_idle;
        integer n;
    begin
        @(posedge i_ref_clk);
        for (n = 0; n < 60 && o_busy !== 1'b0; n = n + 1) @(posedge i_ref_clk);
        if (o_busy !== 1'b0)
        begin
            failures = failures + 1;
            $display("[FAIL] %0t busy never dropped", $time);
        end
    end
    endtask
    task cfg_write(input [31:0] v);
    begin
        wr(4'h0, v); wr(4'h1, 32'h1); wait_idle;
        cmp({12'h0, m_cfg}, v & 32'hf7, ALL);
    end
    endtask
    // Read data watcher and run limit
    always @(posedge i_ref_clk)
    begin
        cyc = cyc + 1;
        if (rd_seen) cmp(o_rdata, exp_q.pop_front(), msk_q.pop_front());
        rd_seen = i_rd;
        if (cyc == 3000)
        begin
            failures = failures + 1;
            $display("[FAIL] %0t run limit reached", $time);
            summarize;
        end
    end
    initial
    begin
        repeat (6) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        repeat (3) @(posedge i_ref_clk);
        rd(4'h3, 32'h70, ALL);
        rd(4'h2, 32'h4, 32'h3f);
        $display("reset test done");
        // Every range code and region codes 0, 3, 4 and 5, each held off by other traffic first
        for (i = 0; i < 4; i = i + 1)
        begin
            seed = xs(seed); d = seed; d[6:5] = i; d[2:0] = regions[i*3 +: 3];
            wr(4'h0, d); i_mem_busy <= 1'b1; wr(4'h1, 32'h1); repeat (6) @(posedge i_ref_clk);
            cmp({29'h0, o_busy, sl_n, cs_n}, 32'h7, ALL);
            i_mem_busy <= 1'b0; wait_idle;
            cmp({12'h0, m_cfg}, d & 32'hf7, ALL);
            rd(4'h3, d & 32'hf7, ALL);
        end
        wr(4'h9, ALL); rd(4'h3, d & 32'hf7, ALL); rd(4'h9, 32'h0, ALL);
        rd(4'h0, d & 32'hf7, ALL);
        $display("config test done");
        cfg_write(32'h10); wr(4'h1, 32'h2); repeat (14) @(posedge i_ref_clk);
        cmp({m_part, m_deep}, 32'h2, ALL); rd(4'h2, 32'h09, 32'h39);
        rd(4'h1, 32'h2, ALL); wr(4'h0, ALL); rd(4'h0, 32'h10, ALL);
        wr(4'h1, 32'h0); repeat (3) @(posedge i_ref_clk);
        cmp({m_part, m_deep}, 32'h0, ALL);
        $display("partial test done");
        cfg_write(32'h800e3); wr(4'h1, 32'ha); repeat (14) @(posedge i_ref_clk);
        cmp({m_part, m_deep}, 32'h1, ALL); rd(4'h2, 32'h39, 32'h39);
        wr(4'h1, 32'h3); rd(4'h3, 32'he3, ALL);
        wr(4'h1, 32'h4); repeat (3) @(posedge i_ref_clk);
        cmp({m_part, m_deep}, 32'h0, ALL); rd(4'h2, 32'h0, 32'h24);
        repeat (14) @(posedge i_ref_clk);
        rd(4'h2, 32'h4, 32'h4); rd(4'h3, 32'he3, ALL);
        $display("deep test done");
        repeat (3) @(posedge i_ref_clk);
        summarize;
    end
endmodule // tb_rcc_host
